/* inc/pin_irq_pkg.sv */
// Package: vector numbers, sense encodings and carrier structs for pin interrupt vectoring
package pin_irq_pkg;

	localparam int NUM_VECTORS = 17;
	localparam int VEC_W = 5;
	localparam int NUM_PC_PINS = 12;
	localparam int PC_LO_W = 8;
	localparam int PC_HI_W = 4;

	// Program addresses of the vector slots
	localparam logic [15:0] ADDR_RESET = 16'h0000;
	localparam logic [15:0] ADDR_EXT_IRQ = 16'h0001;
	localparam logic [15:0] ADDR_PC_LO = 16'h0002;
	localparam logic [15:0] ADDR_PC_HI = 16'h0003;
	localparam logic [15:0] ADDR_WDT = 16'h0004;
	localparam logic [15:0] ADDR_T16_CAPT = 16'h0005;
	localparam logic [15:0] ADDR_T16_OVF = 16'h0008;
	localparam logic [15:0] ADDR_T8_COMPA = 16'h0009;
	localparam logic [15:0] ADDR_T8_OVF = 16'h000B;
	localparam logic [15:0] ADDR_COMPARATOR = 16'h000C;
	localparam logic [15:0] ADDR_SERIAL_OVF = 16'h0010;

	// Source index = vector number - 2 (vector 1 is reset)
	localparam int SRC_EXT = 0;
	localparam int SRC_PC_LO = 1;
	localparam int SRC_PC_HI = 2;
	localparam int NUM_SRC = 16;

	typedef enum logic [1:0] {
		SENSE_LOW = 2'b00,
		SENSE_ANY = 2'b01,
		SENSE_FALL = 2'b10,
		SENSE_RISE = 2'b11
	} sense_t;

	localparam logic [1:0] SENSE_RESET = 2'b00;
	localparam logic [PC_LO_W-1:0] MASK_LO_RESET = 8'h00;
	localparam logic [PC_HI_W-1:0] MASK_HI_RESET = 4'h0;

	typedef struct packed {
		logic ext_en;
		logic pc_lo_en;
		logic pc_hi_en;
		logic [1:0] sense;
		logic [PC_LO_W-1:0] mask_lo;
		logic [PC_HI_W-1:0] mask_hi;
	} pin_cfg_t;

	typedef struct packed {
		logic ext_flag;
		logic pc_lo_flag;
		logic pc_hi_flag;
	} pin_flags_t;

	function automatic logic [15:0] vec_addr(input logic [VEC_W-1:0] vec_num);
		vec_addr = {11'h000, vec_num} - 16'h0001;
	endfunction : vec_addr

endpackage : pin_irq_pkg

/* verilog/pin_sync2.sv */
// Module: two flip-flop synchroniser for a bus of pin levels
module pin_sync2 #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);

	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] sync_q;

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			meta_q <= RESET_VAL;
			sync_q <= RESET_VAL;
		end else begin
			meta_q <= async_i;
			sync_q <= meta_q;
		end
	end

	assign sync_o = sync_q;

endmodule : pin_sync2

/* verilog/vector_arbiter.sv */
// Module: lowest-vector-first priority pick among pending enabled sources
module vector_arbiter #(
	parameter int NSRC = pin_irq_pkg::NUM_SRC
) (
	input wire logic [NSRC-1:0] pending_i,
	output logic valid_o,
	output logic [pin_irq_pkg::VEC_W-1:0] vec_num_o
);

	always_comb begin
		valid_o = 1'b0;
		vec_num_o = '0;
		// Scan downward so the lowest index wins
		for (int i = NSRC - 1; i >= 0; i--) begin
			if (pending_i[i]) begin
				valid_o = 1'b1;
				vec_num_o = pin_irq_pkg::VEC_W'(i + 2);
			end
		end
	end

endmodule : vector_arbiter

/* verilog/pin_irq_vectoring.sv */
// Module: external pin and pin-change interrupt detection with vector selection

//////////////////////////////////////////////////////////////////////////////
// Functional notes
// - Every reset cause starts execution at vector 1, address zero.
// - External pin at 0x0001, pin-change low group 0x0002, high group 0x0003.
// - Watchdog at 0x0004, then 16-bit timer capture, compares, overflow 0x0005-0x0008.
// - 8-bit timer compare A, compare B, overflow at 0x0009, 0x000A, 0x000B.
// - Comparator 0x000C, converter 0x000D, nvdata 0x000E, serial 0x000F and 0x0010.
// - A vector is fetched only when its source is enabled.
// - Pin interrupts fire even when pins are driven as outputs.
// - Low group request on any unmasked toggle of pins 7..0.
// - High group request on any unmasked toggle of pins 11..8.
// - Mask bits choose which pins feed their group request.
// - Pin changes are detected without the I/O clock for deep wake.
// - External pin triggers on falling edge, rising edge or low level.
// - Level mode keeps requesting while the pin stays low.
// - Edge events are recognised only while the I/O clock runs.
// - Low level is detected without a clock for deep wake.
// - I/O clock stops in every sleep mode except idle.
// - Level too short for start-up wakes the core but raises no interrupt.
// - Sense field: 00 low, 01 any change, 10 falling, 11 rising.
// - Pin is sampled before edge detection; pulses over one clock are caught.
// - Group flag sets on change, clears on vector execution or write-one.
// - External flag is held clear while level triggering is selected.
module pin_irq_vectoring (
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic io_clk_run_i,
	input wire logic global_irq_en_i,
	input wire pin_irq_pkg::pin_cfg_t cfg_i,
	input wire logic [2:0] flag_clr_i,
	input wire logic [pin_irq_pkg::NUM_SRC-1:0] periph_req_i,
	input wire logic irq_ack_i,
	input wire logic ext_irq_pin_i,
	input wire logic [pin_irq_pkg::NUM_PC_PINS-1:0] pin_change_inputs_i,
	output pin_irq_pkg::pin_flags_t flags_o,
	output logic wake_o,
	output logic irq_valid_o,
	output logic [pin_irq_pkg::VEC_W-1:0] irq_vec_num_o,
	output logic [15:0] irq_vec_addr_o,
	output logic [15:0] reset_vec_addr_o
);

	localparam int NPC = pin_irq_pkg::NUM_PC_PINS;
	localparam int LO_W = pin_irq_pkg::PC_LO_W;

	logic ext_sync;
	logic [NPC-1:0] pc_sync;
	logic ext_prev_q;
	logic [NPC-1:0] pc_prev_q;
	logic ext_flag_q;
	logic pc_lo_flag_q;
	logic pc_hi_flag_q;
	logic ext_edge;
	logic ext_level_req;
	logic [NPC-1:0] pc_toggle;
	logic [NPC-1:0] pc_mask;
	logic pc_lo_event;
	logic pc_hi_event;
	logic [pin_irq_pkg::NUM_SRC-1:0] pending;
	logic [pin_irq_pkg::VEC_W-1:0] arb_vec;
	logic arb_valid;
	logic [pin_irq_pkg::VEC_W-1:0] vec_num_q;
	logic [15:0] vec_addr_q;
	pin_irq_pkg::sense_t sense;

	//////////////////////////////////////////////////////////////////////////////
	// Pin sampling; pins read back even when the port drives them
	pin_sync2 #(
		.WIDTH(1),
		.RESET_VAL(1'b1)
	) u_ext_sync (
		.ref_clk_i(ref_clk_i),
		.rst_n_i(rst_n_i),
		.async_i(ext_irq_pin_i),
		.sync_o(ext_sync)
	);

	pin_sync2 #(
		.WIDTH(NPC),
		.RESET_VAL('0)
	) u_pc_sync (
		.ref_clk_i(ref_clk_i),
		.rst_n_i(rst_n_i),
		.async_i(pin_change_inputs_i),
		.sync_o(pc_sync)
	);

	assign sense = pin_irq_pkg::sense_t'(cfg_i.sense);
	assign pc_mask = {cfg_i.mask_hi, cfg_i.mask_lo};

	//////////////////////////////////////////////////////////////////////////////
	// External pin edge history; frozen while the I/O clock is stopped
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ext_prev_q <= 1'b1;
		end else if (io_clk_run_i) begin
			ext_prev_q <= ext_sync;
		end
	end

	// Pin-change history runs on every cycle, independent of the I/O clock
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pc_prev_q <= '0;
		end else begin
			pc_prev_q <= pc_sync;
		end
	end

	always_comb begin
		ext_edge = 1'b0;
		case (sense)
			pin_irq_pkg::SENSE_LOW: ext_edge = 1'b0;
			pin_irq_pkg::SENSE_ANY: ext_edge = ext_sync ^ ext_prev_q;
			pin_irq_pkg::SENSE_FALL: ext_edge = ext_prev_q & ~ext_sync;
			pin_irq_pkg::SENSE_RISE: ext_edge = ~ext_prev_q & ext_sync;
			default: ext_edge = 1'b0;
		endcase
		if (!io_clk_run_i) begin
			ext_edge = 1'b0;
		end
	end

	// Level request follows the live pin state, not a stored flag
	assign ext_level_req = (sense == pin_irq_pkg::SENSE_LOW) && !ext_sync;

	assign pc_toggle = (pc_sync ^ pc_prev_q) & pc_mask;
	assign pc_lo_event = |pc_toggle[LO_W-1:0];
	assign pc_hi_event = |pc_toggle[NPC-1:LO_W];

	//////////////////////////////////////////////////////////////////////////////
	// Flags: set beats clear in the same cycle
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ext_flag_q <= 1'b0;
		end else if (sense == pin_irq_pkg::SENSE_LOW) begin
			ext_flag_q <= 1'b0;
		end else if (ext_edge) begin
			ext_flag_q <= 1'b1;
		end else if (flag_clr_i[pin_irq_pkg::SRC_EXT] || (irq_ack_i && vec_num_q == 5'h02)) begin
			ext_flag_q <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pc_lo_flag_q <= 1'b0;
		end else if (pc_lo_event) begin
			pc_lo_flag_q <= 1'b1;
		end else if (flag_clr_i[pin_irq_pkg::SRC_PC_LO] || (irq_ack_i && vec_num_q == 5'h03)) begin
			pc_lo_flag_q <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pc_hi_flag_q <= 1'b0;
		end else if (pc_hi_event) begin
			pc_hi_flag_q <= 1'b1;
		end else if (flag_clr_i[pin_irq_pkg::SRC_PC_HI] || (irq_ack_i && vec_num_q == 5'h04)) begin
			pc_hi_flag_q <= 1'b0;
		end
	end

	assign flags_o = '{ext_flag: ext_flag_q, pc_lo_flag: pc_lo_flag_q, pc_hi_flag: pc_hi_flag_q};

	// Wake is combinational from pins so it works with the I/O clock stopped
	assign wake_o = (cfg_i.ext_en && ext_level_req) || (cfg_i.pc_lo_en && pc_lo_event)
		|| (cfg_i.pc_hi_en && pc_hi_event) || ext_flag_q || pc_lo_flag_q || pc_hi_flag_q;

	//////////////////////////////////////////////////////////////////////////////
	// Pending requests: only enabled sources reach the arbiter
	always_comb begin
		pending = periph_req_i;
		pending[pin_irq_pkg::SRC_EXT] = cfg_i.ext_en && (ext_flag_q || ext_level_req);
		pending[pin_irq_pkg::SRC_PC_LO] = cfg_i.pc_lo_en && pc_lo_flag_q;
		pending[pin_irq_pkg::SRC_PC_HI] = cfg_i.pc_hi_en && pc_hi_flag_q;
		if (!global_irq_en_i) begin
			pending = '0;
		end
	end

	vector_arbiter #(
		.NSRC(pin_irq_pkg::NUM_SRC)
	) u_arb (
		.pending_i(pending),
		.valid_o(arb_valid),
		.vec_num_o(arb_vec)
	);

	// Registered vector; address = vector number - 1 covers every slot
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			vec_num_q <= 5'h00;
			vec_addr_q <= 16'h0000;
			irq_valid_o <= 1'b0;
		end else begin
			irq_valid_o <= arb_valid && !irq_ack_i;
			vec_num_q <= arb_vec;
			vec_addr_q <= pin_irq_pkg::vec_addr(arb_vec);
		end
	end

	assign irq_vec_num_o = vec_num_q;
	assign irq_vec_addr_o = vec_addr_q;
	assign reset_vec_addr_o = pin_irq_pkg::ADDR_RESET;

	//////////////////////////////////////////////////////////////////////////////
	// Checks
	ext_slot_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		irq_valid_o && vec_num_q == 5'h02 |-> irq_vec_addr_o == pin_irq_pkg::ADDR_EXT_IRQ)
		else $error("external vector address wrong");
	pc_slots_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		irq_valid_o && vec_num_q == 5'h04 |-> irq_vec_addr_o == pin_irq_pkg::ADDR_PC_HI)
		else $error("high group vector address wrong");
	timer_slots_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		irq_valid_o && vec_num_q == 5'h09 |-> irq_vec_addr_o == pin_irq_pkg::ADDR_T16_OVF)
		else $error("16-bit overflow vector address wrong");
	t8_slot_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		irq_valid_o && vec_num_q == 5'h0C |-> irq_vec_addr_o == pin_irq_pkg::ADDR_T8_OVF)
		else $error("8-bit overflow vector address wrong");
	serial_slot_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		irq_valid_o && vec_num_q == 5'h11 |-> irq_vec_addr_o == pin_irq_pkg::ADDR_SERIAL_OVF)
		else $error("serial overflow vector address wrong");
	reset_vec_a: assert property (@(posedge ref_clk_i) reset_vec_addr_o == 16'h0000)
		else $error("reset vector not zero");
	gated_fetch_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		!global_irq_en_i |=> !irq_valid_o)
		else $error("vector offered while interrupts disabled");
	lo_toggle_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		pc_lo_event |=> pc_lo_flag_q)
		else $error("low group flag missed a change");
	hi_toggle_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		pc_hi_event |=> pc_hi_flag_q)
		else $error("high group flag missed a change");
	mask_gate_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		cfg_i.mask_lo == '0 && !pc_lo_flag_q && !flag_clr_i[1] |=> !pc_lo_flag_q)
		else $error("masked pins set low group flag");
	level_hold_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		cfg_i.ext_en && global_irq_en_i && ext_level_req && !irq_ack_i |=> irq_valid_o && vec_num_q == 5'h02)
		else $error("level request dropped while pin low");
	edge_stop_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		!io_clk_run_i && !ext_flag_q |=> !ext_flag_q)
		else $error("edge flag set with io clock stopped");
	fall_edge_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		io_clk_run_i && sense == pin_irq_pkg::SENSE_FALL && ext_prev_q && !ext_sync |=> ext_flag_q)
		else $error("falling edge not flagged");
	level_clr_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		sense == pin_irq_pkg::SENSE_LOW |=> !ext_flag_q)
		else $error("external flag set in level mode");
	prio_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		pending[0] |=> vec_num_q == 5'h02)
		else $error("lowest vector not served first");
	pc_lo_slot_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		irq_valid_o && vec_num_q == 5'h03 |-> irq_vec_addr_o == pin_irq_pkg::ADDR_PC_LO)
		else $error("low group vector address wrong");
	wdt_slot_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		irq_valid_o && vec_num_q == 5'h05 |-> irq_vec_addr_o == pin_irq_pkg::ADDR_WDT)
		else $error("watchdog vector address wrong");
	capt_slot_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		irq_valid_o && vec_num_q == 5'h06 |-> irq_vec_addr_o == pin_irq_pkg::ADDR_T16_CAPT)
		else $error("capture vector address wrong");
	t8_compa_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		irq_valid_o && vec_num_q == 5'h0A |-> irq_vec_addr_o == pin_irq_pkg::ADDR_T8_COMPA)
		else $error("8-bit compare A vector address wrong");
	comp_slot_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		irq_valid_o && vec_num_q == 5'h0D |-> irq_vec_addr_o == pin_irq_pkg::ADDR_COMPARATOR)
		else $error("comparator vector address wrong");
	hi_mask_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		cfg_i.mask_hi == '0 && !pc_hi_flag_q |=> !pc_hi_flag_q)
		else $error("masked pins set high group flag");
	level_wake_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		cfg_i.ext_en && sense == pin_irq_pkg::SENSE_LOW && !ext_sync |-> wake_o)
		else $error("low level did not raise wake");
	rise_edge_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		io_clk_run_i && sense == pin_irq_pkg::SENSE_RISE && !ext_prev_q && ext_sync |=> ext_flag_q)
		else $error("rising edge not flagged");
	any_edge_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		io_clk_run_i && sense == pin_irq_pkg::SENSE_ANY && (ext_prev_q != ext_sync) |=> ext_flag_q)
		else $error("pin change not flagged");
	ack_clr_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		irq_ack_i && vec_num_q == 5'h03 && !pc_lo_event |=> !pc_lo_flag_q)
		else $error("low group flag kept after its vector");
	write_clr_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		flag_clr_i[pin_irq_pkg::SRC_PC_HI] && !pc_hi_event |=> !pc_hi_flag_q)
		else $error("high group flag kept after write one");
	ack_drop_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		irq_ack_i |=> !irq_valid_o)
		else $error("vector still offered after ack");

	pc_wake_c: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i) pc_hi_event && !io_clk_run_i);
	ext_serve_c: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i) irq_valid_o && vec_num_q == 5'h02);
	both_pend_c: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i) pending[1] && pending[2]);
	level_wake_c: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i) wake_o && !io_clk_run_i && ext_level_req);
	lo_ack_c: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i) irq_ack_i && vec_num_q == 5'h03);

endmodule : pin_irq_vectoring

/* tb/pin_driver_model.sv */
// Partner model: outside drivers of the external interrupt pin and the pin-change pins
module pin_driver_model (
	input wire logic ext_level_i,
	input wire logic [11:0] pc_level_i,
	output logic ext_irq_pin_o,
	output logic [11:0] pin_change_inputs_o
);
	timeunit 1ns;
	timeprecision 1ps;

	// A pin driven by the device itself as an output looks the same here: level in, level out
	// Small delay keeps pin edges clear of the sampling clock edge
	assign #1 ext_irq_pin_o = ext_level_i;
	assign #1 pin_change_inputs_o = pc_level_i;
endmodule : pin_driver_model

/* tb/tb_pin_irq_vectoring.sv */
// Testbench: pin interrupt detection, flags and vector selection
module tb_pin_irq_vectoring;
	timeunit 1ns;
	timeprecision 1ps;

	logic ref_clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic io_clk_run_i = 1'b1;
	logic global_irq_en_i = 1'b0;
	logic irq_ack_i = 1'b0;
	logic [2:0] flag_clr_i = 3'h0;
	logic [15:0] periph_req_i = 16'h0000;
	pin_irq_pkg::pin_cfg_t cfg_i = '0;
	logic ext_lvl = 1'b1;
	logic [11:0] pc_lvl = 12'h000;
	logic ext_pin;
	logic [11:0] pc_pins;
	pin_irq_pkg::pin_flags_t flags_o;
	logic wake_o;
	logic irq_valid_o;
	logic [4:0] irq_vec_num_o;
	logic [15:0] irq_vec_addr_o;
	logic [15:0] reset_vec_addr_o;
	int error_cnt = 0;
	int checks = 0;

	always #5 ref_clk_i = ~ref_clk_i;

	pin_driver_model pins (.ext_level_i(ext_lvl), .pc_level_i(pc_lvl), .ext_irq_pin_o(ext_pin),
		.pin_change_inputs_o(pc_pins));

	pin_irq_vectoring dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .io_clk_run_i(io_clk_run_i),
		.global_irq_en_i(global_irq_en_i), .cfg_i(cfg_i), .flag_clr_i(flag_clr_i),
		.periph_req_i(periph_req_i), .irq_ack_i(irq_ack_i), .ext_irq_pin_i(ext_pin),
		.pin_change_inputs_i(pc_pins), .flags_o(flags_o), .wake_o(wake_o), .irq_valid_o(irq_valid_o),
		.irq_vec_num_o(irq_vec_num_o), .irq_vec_addr_o(irq_vec_addr_o), .reset_vec_addr_o(reset_vec_addr_o));

	//////////////////////////////////////////////////////////////////////////////
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk_i);
	endtask : cyc

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// Waits a bounded time for a request, then compares number and address
	task automatic chk_vec(input int n);
		int k;
		k = 0;
		@(negedge ref_clk_i);
		while (irq_valid_o !== 1'b1 && k < 20) begin
			@(negedge ref_clk_i);
			k++;
		end
		chk("vector valid", 16'h0001, {15'h0000, irq_valid_o});
		chk("vector number", 16'(n), {11'h000, irq_vec_num_o});
		chk("vector address", 16'(n - 1), irq_vec_addr_o);
	endtask : chk_vec

	// Core takes the vector; peripheral requests are withdrawn at the same time
	task automatic ack();
		@(posedge ref_clk_i);
		irq_ack_i <= 1'b1;
		periph_req_i <= 16'h0000;
		@(posedge ref_clk_i);
		irq_ack_i <= 1'b0;
		@(negedge ref_clk_i);
	endtask : ack

	task automatic clr_flag(input logic [2:0] m);
		@(posedge ref_clk_i);
		flag_clr_i <= m;
		@(posedge ref_clk_i);
		flag_clr_i <= 3'h0;
		@(negedge ref_clk_i);
	endtask : clr_flag

	// Pin goes low, then high; flag looked at after each move
	task automatic ext_case(input logic [1:0] s, input logic e1, input logic e2);
		@(posedge ref_clk_i);
		cfg_i.sense <= s;
		ext_lvl <= 1'b0;
		cyc(6);
		@(negedge ref_clk_i);
		chk("ext flag after fall", {15'h0000, e1}, {15'h0000, flags_o.ext_flag});
		@(posedge ref_clk_i);
		ext_lvl <= 1'b1;
		cyc(6);
		@(negedge ref_clk_i);
		chk("ext flag after rise", {15'h0000, e2}, {15'h0000, flags_o.ext_flag});
		clr_flag(3'h1);
		chk("ext flag cleared", 16'h0000, {15'h0000, flags_o.ext_flag});
	endtask : ext_case

	task automatic print_verdict();
		$display("Checks %0d errors %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : print_verdict

	//////////////////////////////////////////////////////////////////////////////
	initial begin
		cyc(5);
		rst_n_i <= 1'b1;
		cyc(4);
		@(negedge ref_clk_i);
		chk("reset vector", 16'h0000, reset_vec_addr_o);
		chk("flags after reset", 16'h0000, {13'h0000, flags_o});
		chk("valid after reset", 16'h0000, {15'h0000, irq_valid_o});
		@(posedge ref_clk_i);
		global_irq_en_i <= 1'b1;
		for (int i = 3; i < 16; i++) begin
			@(posedge ref_clk_i);
			periph_req_i <= 16'h0001 << i;
			chk_vec(i + 2);
			ack();
		end
		@(posedge ref_clk_i);
		periph_req_i <= 16'h0408;
		chk_vec(5);
		ack();
		// Pin-change detection with the I/O clock stopped
		@(posedge ref_clk_i);
		cfg_i.mask_lo <= 8'h01;
		io_clk_run_i <= 1'b0;
		pc_lvl <= 12'h020;
		cyc(8);
		@(negedge ref_clk_i);
		chk("masked pin flag", 16'h0000, {15'h0000, flags_o.pc_lo_flag});
		@(posedge ref_clk_i);
		pc_lvl <= 12'h021;
		cyc(6);
		@(negedge ref_clk_i);
		chk("low group flag", 16'h0001, {15'h0000, flags_o.pc_lo_flag});
		chk("disabled source valid", 16'h0000, {15'h0000, irq_valid_o});
		@(posedge ref_clk_i);
		cfg_i.pc_lo_en <= 1'b1;
		cfg_i.pc_hi_en <= 1'b1;
		cfg_i.mask_hi <= 4'h2;
		pc_lvl <= 12'h221;
		cyc(6);
		@(negedge ref_clk_i);
		chk("pin change wake", 16'h0001, {15'h0000, wake_o});
		chk_vec(3);
		ack();
		chk("low flag after ack", 16'h0000, {15'h0000, flags_o.pc_lo_flag});
		chk_vec(4);
		ack();
		chk("high flag after ack", 16'h0000, {15'h0000, flags_o.pc_hi_flag});
		@(posedge ref_clk_i);
		io_clk_run_i <= 1'b1;
		global_irq_en_i <= 1'b0;
		pc_lvl <= 12'h020;
		cyc(6);
		clr_flag(3'h6);
		chk("low flag write one", 16'h0000, {15'h0000, flags_o.pc_lo_flag});
		chk("high flag write one", 16'h0000, {15'h0000, flags_o.pc_hi_flag});
		// External pin sense modes
		@(posedge ref_clk_i);
		cfg_i.ext_en <= 1'b1;
		ext_case(2'b01, 1'b1, 1'b1);
		ext_case(2'b10, 1'b1, 1'b1);
		ext_case(2'b11, 1'b0, 1'b1);
		@(posedge ref_clk_i);
		cfg_i.sense <= 2'b10;
		io_clk_run_i <= 1'b0;
		ext_lvl <= 1'b0;
		cyc(6);
		@(negedge ref_clk_i);
		chk("edge while asleep", 16'h0000, {15'h0000, flags_o.ext_flag});
		@(posedge ref_clk_i);
		cfg_i.sense <= 2'b00;
		cyc(5);
		@(negedge ref_clk_i);
		chk("level wake", 16'h0001, {15'h0000, wake_o});
		chk("level mode flag", 16'h0000, {15'h0000, flags_o.ext_flag});
		@(posedge ref_clk_i);
		io_clk_run_i <= 1'b1;
		global_irq_en_i <= 1'b1;
		chk_vec(2);
		ack();
		chk_vec(2);
		@(posedge ref_clk_i);
		ext_lvl <= 1'b1;
		cyc(6);
		@(negedge ref_clk_i);
		chk("level gone valid", 16'h0000, {15'h0000, irq_valid_o});
		print_verdict();
	end

	initial begin
		cyc(20000);
		error_cnt++;
		print_verdict();
	end
endmodule : tb_pin_irq_vectoring
